// file: include/guard_interlock_pkg.sv
// package of shared constants and carrier types for the guard interlock controller
// assumes a single 250 MHz clock and that power cycling is the only reset
package guard_interlock_pkg;

    localparam int unsigned CLK_HZ = 250_000_000; // device clock rate
    localparam int unsigned TICK_US = 1000; // time base tick, microseconds
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US; // cycles a tick
    localparam int unsigned TEACH_WAIT_S = 10; // teach display before power-off request
    localparam int unsigned TEACH_ABORT_MIN = 5; // wait for power off before abort
    localparam int unsigned INHIBIT_MIN = 10; // tamper inhibit after re-teach
    localparam int unsigned WARN_MIN = 30; // warning becomes shutdown
    localparam int unsigned TEACH_WAIT_TICKS = TEACH_WAIT_S * 1_000_000 / TICK_US;
    localparam int unsigned TEACH_ABORT_TICKS = TEACH_ABORT_MIN * 60_000_000 / TICK_US;
    localparam int unsigned INHIBIT_TICKS = INHIBIT_MIN * 60_000_000 / TICK_US;
    localparam int unsigned WARN_TICKS = WARN_MIN * 60_000_000 / TICK_US;
    localparam logic [3:0] DEBOUNCE_TICKS = 4'h5; // stable ticks before an input is taken
    localparam logic [11:0] BLINK1_HALF_TICKS = 12'h1F4; // 500 ms half period, 1 Hz
    localparam logic [11:0] BLINK3_PERIOD_TICKS = 12'h14D; // 333 ms, 3 Hz
    localparam logic [11:0] BLINK3_ON_TICKS = 12'h03C; // 60 ms short flash
    localparam logic [11:0] FLASH_SLOT_TICKS = 12'h1F4; // 500 ms per flash slot
    localparam logic [11:0] FLASH_ON_TICKS = 12'h0C8; // 200 ms lit in a slot
    localparam logic [3:0] FLASH_PAUSE_SLOTS = 4'h3; // dark slots after a code
    localparam logic [2:0] CODE_NONE = 3'h0; // fault indicator dark
    localparam logic [2:0] CODE_OUT_A = 3'h1; // warning on first output
    localparam logic [2:0] CODE_OUT_B = 3'h2; // warning on second output
    localparam logic [2:0] CODE_CROSS = 3'h3; // cross-short or double output fault
    localparam logic [2:0] CODE_TEMP = 3'h4; // overtemperature
    localparam logic [2:0] CODE_ACTUATOR = 3'h5; // wrong or defective actuator
    localparam logic [2:0] CODE_COMBO = 3'h6; // invalid actuator combination
    localparam logic [2:0] CODE_STEADY = 3'h7; // internal or supply fault, lit steady

    typedef enum logic [2:0] {
        ST_INIT = 3'b000, // first cycle after power-up
        ST_RUN = 3'b001, // normal operation
        ST_TEACH = 3'b010, // new code being learned
        ST_TEACH_PWR = 3'b011, // waiting for operating power removal
        ST_ABORT = 3'b100, // teaching cancelled, until power cycle
        ST_CONFIRM = 3'b101, // pending code awaits re-detection
        ST_INHIBIT = 3'b110 // tamper inhibit after re-teach
    } state_type;

    typedef struct packed {
        logic power; // green
        logic status; // yellow
        logic fault; // red
    } led_type;

    typedef struct packed {
        logic individual_coding; // 0 = standard coding
        logic one_time_teach_variant; // teach once only
        logic reteachable_variant; // teach repeatedly with inhibit
        logic power_to_lock; // 0 = power-to-unlock
        logic guard_position_variant; // outputs follow guard, not lock
    } straps_type;

    typedef struct packed {
        logic internal_error; // safety-relevant internal error
        logic supply_fault; // over- or undervoltage
        logic actuator_fault; // defective actuator
        logic combo_fault; // invalid actuator combination
        logic out_a_fault; // first safety output fault
        logic out_b_fault; // second safety output fault
        logic cross_short; // short between the outputs
        logic overtemp; // temperature too high
    } faults_type;

endpackage : guard_interlock_pkg

// file: hdl/guard_interlock_controller.sv
// control logic of a coded, solenoid-locked guard interlock
// assumes raw sensor pins are asynchronous; faults, code match and store flags are on mclk
`timescale 1ns/1ps
`default_nettype none
module guard_interlock_controller
    import guard_interlock_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES, // cycles per time base tick
    parameter int unsigned TEACH_WAIT_LEN = TEACH_WAIT_TICKS, // ticks
    parameter int unsigned TEACH_ABORT_LEN = TEACH_ABORT_TICKS, // ticks
    parameter int unsigned INHIBIT_LEN = INHIBIT_TICKS, // ticks
    parameter int unsigned WARN_LEN = WARN_TICKS // ticks
) (
    input wire logic mclk, // device clock
    input wire logic nrst, // power-on reset, active low
    input wire straps_type straps, // variant configuration levels
    input wire logic magnet_in, // magnet control pin, high = 24 V
    input wire logic guard_closed_in, // guard closed sensor pin
    input wire logic actuator_present_in, // actuator inserted sensor pin
    input wire logic bolt_engaged_in, // bolt position sensor pin
    input wire logic actuator_match, // detected code equals active or pending code
    input wire logic code_stored, // a permanent code exists
    input wire logic code_pending, // a taught code awaits activation
    input wire logic inhibit_pending, // inhibit was running at power loss
    input wire faults_type faults, // fault detector levels
    output logic safety_output_a, // first safety output enable
    output logic safety_output_b, // second safety output enable
    output logic bolt_release, // solenoid drive, high releases bolt
    output logic diag_out, // non-safety diagnostic output
    output led_type leds, // indicator drive
    output logic code_capture, // pulse: keep detected code as pending
    output logic code_commit, // pulse: make pending code permanent
    output logic inhibit_store // level: inhibit running, kept across power loss
);

    typedef struct packed {
        logic [3:0] sync1; // first synchroniser stage
        logic [3:0] sync2; // second synchroniser stage
        logic [3:0] deb; // debounced levels
        logic [3:0][3:0] deb_cnt; // stability counters
        logic [17:0] tick_cnt; // time base divider
        logic tick; // one-cycle tick pulse
        state_type st; // sequence state
        logic [20:0] tmr; // teach and inhibit timer, ticks
        logic err; // latched internal error
        logic seen_open; // guard opened since cause gone
        logic [2:0] err_code; // code of the latched error
        logic lockout; // held until power cycle
        logic [20:0] wtmr; // warning duration, ticks
        logic wexp; // warning ran out
        logic [11:0] b1_cnt; // 1 Hz blink timer
        logic b1; // 1 Hz blink level
        logic [11:0] b3_cnt; // 3 Hz blink timer
        logic [11:0] fl_t; // time within a flash slot
        logic [3:0] fl_n; // flash slot index
        logic sa; // safety output a
        logic sb; // safety output b
        logic rel; // bolt release drive
        logic diag; // diagnostic output
        led_type led; // indicators
        logic cap; // capture pulse
        logic com; // commit pulse
        logic inh; // inhibit store level
    } gic_state_type;

    gic_state_type s_q; // registered state
    gic_state_type s_d; // next state

    logic magnet; // debounced magnet level
    logic closed; // debounced guard closed
    logic present; // debounced actuator inserted
    logic bolt; // debounced bolt engaged
    logic lock_cmd; // lock requested by the magnet input
    logic blocked; // lock requested but bolt not engaged
    logic refused; // unknown actuator while teaching is not allowed
    logic err_src; // any error cause present now
    logic lock_src; // cause that latches lockout
    logic warn; // non-critical warning present
    logic accepted; // actuator valid for operation
    logic enable; // safety outputs may be enabled
    logic [2:0] fcode; // code shown on the fault indicator

    assign magnet = s_q.deb[0];
    assign closed = s_q.deb[1];
    assign present = s_q.deb[2];
    assign bolt = s_q.deb[3];
    // polarity of the magnet input depends on the variant
    assign lock_cmd = straps.power_to_lock ? magnet : ~magnet;
    assign blocked = lock_cmd & ~bolt;
    assign accepted = ~straps.individual_coding | actuator_match;
    // a stored code in the one-time variant can never be replaced
    assign refused = (s_q.st == ST_RUN) & straps.individual_coding
        & straps.one_time_teach_variant & code_stored & present & ~actuator_match;
    assign err_src = faults.internal_error | faults.supply_fault | faults.actuator_fault
        | faults.combo_fault | refused;
    // a second output fault or a cross-short means the outputs cannot be trusted again
    assign lock_src = (faults.out_a_fault & faults.out_b_fault) | faults.cross_short;
    assign warn = faults.out_a_fault | faults.out_b_fault | faults.overtemp;
    // err_src is used directly so the outputs drop one cycle after the cause
    assign enable = (s_q.st == ST_RUN) & closed & present & accepted
        & (straps.guard_position_variant | bolt)
        & ~err_src & ~s_q.err & ~s_q.lockout & ~s_q.wexp;

    // fault indicator code, most severe first
    always_comb begin
        fcode = CODE_NONE;
        if (s_q.st == ST_ABORT) begin
            fcode = CODE_ACTUATOR;
        end else if (s_q.lockout) begin
            fcode = CODE_CROSS;
        end else if (s_q.err) begin
            fcode = s_q.err_code;
        end else if (faults.out_a_fault) begin
            fcode = CODE_OUT_A;
        end else if (faults.out_b_fault) begin
            fcode = CODE_OUT_B;
        end else if (faults.overtemp) begin
            fcode = CODE_TEMP;
        end
    end

    // whole next-state function
    always_comb begin
        s_d = s_q;
        s_d.cap = 1'b0;
        s_d.com = 1'b0;
        // time base, one tick per TICK_LEN cycles
        s_d.tick = 1'b0;
        if (s_q.tick_cnt == 18'(TICK_LEN - 1)) begin
            s_d.tick_cnt = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.tick_cnt = s_q.tick_cnt + 18'h0_0001;
        end
        // two-stage sync, then debounce over whole ticks
        s_d.sync1 = {bolt_engaged_in, actuator_present_in, guard_closed_in, magnet_in};
        s_d.sync2 = s_q.sync1;
        for (int i = 0; i < 4; i++) begin
            if (s_q.sync2[i] == s_q.deb[i]) begin
                s_d.deb_cnt[i] = 4'h0;
            end else if (s_q.tick) begin
                if (s_q.deb_cnt[i] == DEBOUNCE_TICKS - 4'h1) begin
                    s_d.deb[i] = s_q.sync2[i];
                    s_d.deb_cnt[i] = 4'h0;
                end else begin
                    s_d.deb_cnt[i] = s_q.deb_cnt[i] + 4'h1;
                end
            end
        end
        // teach and activation sequence
        case (s_q.st)
            ST_INIT: begin
                s_d.tmr = '0;
                if (inhibit_pending & straps.reteachable_variant) begin
                    s_d.st = ST_INHIBIT;
                    s_d.inh = 1'b1;
                end else if (code_pending & straps.individual_coding) begin
                    s_d.st = ST_CONFIRM;
                end else begin
                    s_d.st = ST_RUN;
                end
            end
            ST_RUN: begin
                // teach allowed unless a one-time code is already stored
                if (straps.individual_coding & present & ~actuator_match
                    & ~(straps.one_time_teach_variant & code_stored)) begin
                    s_d.st = ST_TEACH;
                    s_d.cap = 1'b1;
                    s_d.tmr = '0;
                end
            end
            ST_TEACH: begin
                if (s_q.tick) begin
                    if (s_q.tmr == 21'(TEACH_WAIT_LEN - 1)) begin
                        s_d.st = ST_TEACH_PWR;
                        s_d.tmr = '0;
                    end else begin
                        s_d.tmr = s_q.tmr + 21'h00_0001;
                    end
                end
            end
            ST_TEACH_PWR: begin
                if (s_q.tick) begin
                    if (s_q.tmr == 21'(TEACH_ABORT_LEN - 1)) begin
                        s_d.st = ST_ABORT;
                    end else begin
                        s_d.tmr = s_q.tmr + 21'h00_0001;
                    end
                end
            end
            ST_ABORT: begin
                s_d.st = ST_ABORT; // only a power cycle leaves
            end
            ST_CONFIRM: begin
                if (present & actuator_match) begin
                    s_d.com = 1'b1;
                    s_d.tmr = '0;
                    if (straps.reteachable_variant) begin
                        s_d.st = ST_INHIBIT;
                        s_d.inh = 1'b1;
                    end else begin
                        s_d.st = ST_RUN;
                    end
                end
            end
            ST_INHIBIT: begin
                if (s_q.tick & (s_q.tmr != 21'(INHIBIT_LEN))) begin
                    s_d.tmr = s_q.tmr + 21'h00_0001;
                end
                // both the time and a fresh detection are needed to leave
                if ((s_q.tmr == 21'(INHIBIT_LEN)) & present & actuator_match) begin
                    s_d.st = ST_RUN;
                    s_d.inh = 1'b0;
                end
            end
            default: begin
                s_d.st = ST_INIT;
            end
        endcase
        // internal error, set wins over the clearing sequence
        if (err_src) begin
            s_d.err = 1'b1;
            s_d.seen_open = 1'b0;
            if (faults.actuator_fault | refused) begin
                s_d.err_code = CODE_ACTUATOR;
            end else if (faults.combo_fault) begin
                s_d.err_code = CODE_COMBO;
            end else begin
                s_d.err_code = CODE_STEADY;
            end
        end else if (s_q.err) begin
            if (~closed) begin
                s_d.seen_open = 1'b1;
            end else if (s_q.seen_open) begin
                s_d.err = 1'b0;
            end
        end
        if (lock_src) begin
            s_d.lockout = 1'b1;
        end
        // warning duration, reset as soon as the cause is gone
        if (~warn) begin
            s_d.wtmr = '0;
            s_d.wexp = 1'b0;
        end else if (s_q.tick & ~s_q.wexp) begin
            if (s_q.wtmr == 21'(WARN_LEN - 1)) begin
                s_d.wexp = 1'b1;
            end else begin
                s_d.wtmr = s_q.wtmr + 21'h00_0001;
            end
        end
        // blink generators, all on the tick
        if (s_q.tick) begin
            if (s_q.b1_cnt == BLINK1_HALF_TICKS - 12'h001) begin
                s_d.b1_cnt = '0;
                s_d.b1 = ~s_q.b1;
            end else begin
                s_d.b1_cnt = s_q.b1_cnt + 12'h001;
            end
            if (s_q.b3_cnt == BLINK3_PERIOD_TICKS - 12'h001) begin
                s_d.b3_cnt = '0;
            end else begin
                s_d.b3_cnt = s_q.b3_cnt + 12'h001;
            end
            if (s_q.fl_t == FLASH_SLOT_TICKS - 12'h001) begin
                s_d.fl_t = '0;
                if (s_q.fl_n >= {1'b0, fcode} + FLASH_PAUSE_SLOTS - 4'h1) begin
                    s_d.fl_n = '0;
                end else begin
                    s_d.fl_n = s_q.fl_n + 4'h1;
                end
            end else begin
                s_d.fl_t = s_q.fl_t + 12'h001;
            end
        end
        // outputs, each from a flip-flop
        s_d.sa = enable;
        s_d.sb = enable;
        s_d.rel = ~lock_cmd;
        s_d.diag = (s_q.st == ST_RUN) & closed & present & accepted & ~blocked
            & ~err_src & ~s_q.err & ~s_q.lockout & ~warn;
        s_d.led.power = 1'b1;
        s_d.led.status = 1'b0;
        if (fcode == CODE_STEADY) begin
            s_d.led.fault = 1'b1;
        end else begin
            s_d.led.fault = (s_q.fl_n < {1'b0, fcode}) & (s_q.fl_t < FLASH_ON_TICKS);
        end
        case (s_q.st)
            ST_TEACH: begin
                s_d.led.power = 1'b0;
                s_d.led.fault = 1'b1;
                s_d.led.status = s_q.b1;
            end
            ST_TEACH_PWR: begin
                s_d.led.power = 1'b0;
                s_d.led.fault = 1'b1;
                s_d.led.status = s_q.b3_cnt < BLINK3_ON_TICKS;
            end
            ST_INHIBIT: begin
                s_d.led.power = s_q.b1;
                s_d.led.fault = 1'b0;
            end
            ST_RUN: begin
                // lit when locked, blinking when inserted but not locked
                if (closed & present & ~s_q.err & ~s_q.lockout) begin
                    s_d.led.status = bolt ? 1'b1 : s_q.b1;
                end
            end
            default: begin
                s_d.led.status = 1'b0;
            end
        endcase
    end

    // single state register, constants only under reset
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign safety_output_a = s_q.sa;
    assign safety_output_b = s_q.sb;
    assign bolt_release = s_q.rel;
    assign diag_out = s_q.diag;
    assign leds = s_q.led;
    assign code_capture = s_q.cap;
    assign code_commit = s_q.com;
    assign inhibit_store = s_q.inh;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    property p_teach_leds;
        s_q.st == ST_TEACH |=> !leds.power && leds.fault;
    endproperty
    a_teach_leds: assert property (p_teach_leds) else $error("teach indicators wrong");

    property p_teach_wait;
        (s_q.st == ST_TEACH && s_q.tick && s_q.tmr == 21'(TEACH_WAIT_LEN - 1))
            |=> s_q.st == ST_TEACH_PWR;
    endproperty
    a_teach_wait: assert property (p_teach_wait) else $error("no power-off request");

    property p_abort_entry;
        (s_q.st == ST_ABORT && $past(s_q.st) != ST_ABORT) |-> $past(s_q.st) == ST_TEACH_PWR;
    endproperty
    a_abort_entry: assert property (p_abort_entry) else $error("abort from wrong state");

    property p_commit;
        code_commit |-> $past(s_q.st == ST_CONFIRM && actuator_match && present);
    endproperty
    a_commit: assert property (p_commit) else $error("commit without re-detection");

    property p_inhibit_off;
        s_q.st == ST_INHIBIT |=> !safety_output_a && !safety_output_b;
    endproperty
    a_inhibit_off: assert property (p_inhibit_off) else $error("outputs on in inhibit");

    property p_err_off;
        err_src |=> !safety_output_a && !safety_output_b;
    endproperty
    a_err_off: assert property (p_err_off) else $error("outputs on after error");

    property p_lockout;
        s_q.lockout |=> s_q.lockout && !safety_output_a ##1 s_q.lockout;
    endproperty
    a_lockout: assert property (p_lockout) else $error("lockout released");

    property p_warn_diag;
        warn |=> !diag_out;
    endproperty
    a_warn_diag: assert property (p_warn_diag) else $error("diag high in warning");

    property p_warn_timeout;
        s_q.wexp |=> !safety_output_a && !safety_output_b;
    endproperty
    a_warn_timeout: assert property (p_warn_timeout) else $error("outputs on after timeout");

    property p_bolt;
        ##1 1'b1 |-> bolt_release == (straps.power_to_lock ? !$past(magnet) : $past(magnet));
    endproperty
    a_bolt: assert property (p_bolt) else $error("bolt drive polarity wrong");

endmodule : guard_interlock_controller
`default_nettype wire

// file: verif/plc_model.sv
// far-side controller model: drives the magnet pin, keeps the inhibit flag over power loss
// assumes the bench asks for unlocking by level and cycles power through nrst
`timescale 1ns/1ps
`default_nettype none
module plc_model (
    input wire logic mclk, // device clock
    input wire logic unlock_req, // bench wants the guard free
    input wire logic to_lock, // variant: power-to-lock
    input wire logic inhibit_store, // device flag to keep
    input wire logic released, // safety outputs enabled again
    output logic magnet_in, // magnet control pin
    output logic inhibit_pending // kept flag, survives power loss
);
    logic nv_q = 1'b0; // nonvolatile copy, reset never touches it
    // pin level for the wanted bolt state, inverted for power-to-lock
    assign magnet_in = to_lock ? !unlock_req : unlock_req;
    // flag kept while the inhibit runs, dropped once the outputs come back
    always @(posedge mclk) begin
        if (inhibit_store) nv_q <= 1'b1;
        else if (released) nv_q <= 1'b0;
    end
    assign inhibit_pending = nv_q;
endmodule : plc_model
`default_nettype wire

// file: verif/guard_interlock_controller_tb.sv
// bench for the guard interlock controller: pin sequences with expected levels
// assumes shortened timing parameters; nrst stands for power cycling
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module guard_interlock_controller_tb;
    import guard_interlock_pkg::*;
    localparam int DB = 40; // sync plus five debounce ticks, with margin
    logic mclk = 1'b0, nrst = 1'b0; // clock and power
    straps_type straps = '0; // variant levels
    faults_type faults = '0; // fault detector levels
    logic closed = 1'b1, present = 1'b1, bolt = 1'b1, match = 1'b0; // sensors
    logic stored = 1'b0, pending = 1'b0, unlock = 1'b0; // memory view, lock wish
    logic magnet, inh_pend, inh_st, sa, sb, rel, diag, cap, com;
    led_type leds; // indicators
    int fails = 0, checks = 0, cyc = 0;
    int cap_n = 0, com_n = 0, cap0 = 0; // pulse counts, only the catcher writes cap_n and com_n
    always #2 mclk = ~mclk; // 250 MHz
    guard_interlock_controller #(.TICK_LEN(4), .TEACH_WAIT_LEN(20), .TEACH_ABORT_LEN(30),
        .INHIBIT_LEN(40), .WARN_LEN(50)) DUT (.mclk(mclk), .nrst(nrst), .straps(straps),
        .magnet_in(magnet), .guard_closed_in(closed), .actuator_present_in(present),
        .bolt_engaged_in(bolt), .actuator_match(match), .code_stored(stored),
        .code_pending(pending), .inhibit_pending(inh_pend), .faults(faults),
        .safety_output_a(sa), .safety_output_b(sb), .bolt_release(rel), .diag_out(diag),
        .leds(leds), .code_capture(cap), .code_commit(com), .inhibit_store(inh_st));
    plc_model far (.mclk(mclk), .unlock_req(unlock), .to_lock(straps.power_to_lock),
        .inhibit_store(inh_st), .released(sa), .magnet_in(magnet), .inhibit_pending(inh_pend));
    task automatic give_verdict();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : give_verdict
    task automatic wt(input int n); // inputs move at the falling edge only
        repeat (n) @(negedge mclk);
    endtask : wt
    task automatic power_up(input straps_type s); // straps only change while unpowered
        nrst = 1'b0;
        straps = s;
        wt(8);
        nrst = 1'b1;
        wt(60);
    endtask : power_up
    // pulse catchers and the hang limit
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cap) cap_n <= cap_n + 1;
        if (com) com_n <= com_n + 1;
        if (cyc == 6000) begin
            fails++;
            give_verdict();
        end
    end
    initial begin
        for (int p = 0; p < 2; p++) begin // both magnet forms, standard coding
            power_up({3'h0, p[0], 1'b0});
            `CHK({sa, sb, diag, rel, leds}, 7'h76)
            bolt = 1'b0;
            wt(DB);
            `CHK({sa, diag}, 2'h0)
            unlock = 1'b1;
            wt(DB);
            `CHK({sa, sb, diag, rel}, 4'h3)
            unlock = 1'b0;
            bolt = 1'b1;
            wt(DB);
            `CHK({sa, sb, diag, rel}, 4'he)
        end
        faults.overtemp = 1'b1;
        wt(3);
        `CHK({sa, sb, diag}, 3'h6)
        faults.overtemp = 1'b0;
        wt(3);
        `CHK(diag, 1'b1)
        faults.out_a_fault = 1'b1;
        wt(210);
        `CHK({sa, sb}, 2'h0)
        faults.out_a_fault = 1'b0;
        wt(3);
        `CHK({sa, sb, diag}, 3'h7)
        faults.internal_error = 1'b1;
        wt(2);
        `CHK({sa, sb}, 2'h0)
        faults.internal_error = 1'b0;
        wt(DB);
        `CHK({sa, sb}, 2'h0)
        closed = 1'b0;
        wt(DB);
        closed = 1'b1;
        wt(DB);
        `CHK({sa, sb, diag}, 3'h7)
        faults.cross_short = 1'b1;
        wt(3);
        faults.cross_short = 1'b0;
        closed = 1'b0;
        wt(DB);
        closed = 1'b1;
        wt(DB);
        `CHK({sa, sb}, 2'h0)
        power_up(5'h01); // guard-position variant, bolt left free
        bolt = 1'b0;
        unlock = 1'b1;
        wt(DB);
        `CHK({sa, sb}, 2'h3)
        closed = 1'b0;
        wt(DB);
        `CHK({sa, sb}, 2'h0)
        closed = 1'b1;
        bolt = 1'b1;
        unlock = 1'b0;
        power_up(5'h14); // re-teachable unit meets an unknown actuator
        `CHK({cap_n == 1, leds.power, leds.fault, sa}, 4'ha)
        wt(210);
        `CHK({leds.power, sa, sb}, 3'h4)
        pending = 1'b1;
        match = 1'b1;
        power_up(5'h14);
        `CHK({com_n == 1, inh_st, sa}, 3'h6)
        pending = 1'b0;
        wt(80);
        power_up(5'h14); // power lost mid-inhibit
        wt(40);
        `CHK({inh_st, sa}, 2'h2)
        wt(160);
        `CHK({inh_st, sa}, 2'h1)
        cap0 = cap_n;
        match = 1'b0;
        stored = 1'b1;
        power_up(5'h18); // one-time unit already paired
        `CHK({cap_n == cap0, sa}, 2'h2)
        give_verdict();
    end
endmodule : guard_interlock_controller_tb
`default_nettype wire
